// file: src/pmg_periph_gate.sv
// Peripheral module gating controller with APB register access
//
// How it works
// R1: Disabled module gets no clock or controls
// R2: Disabled module held in reset
// R3: Disabled module: writes dropped, reads 00h
// R4: Disabled module: analog off, digital outputs zero
// R5: Re-enabled module starts from reset values
// R6: Re-enable completes within one instruction cycle; the code releases reset WAKE_CYCLES + 1 = 5 clocks after the bit clears
// R7: Software waits one instruction after re-enable
// R8: Clock gate bit stops peripheral system clock
// R9: Control register zero bit layout, 5:3 zero
// R10: Bit one disables, zero enables
// R11: Memory disable blocks data memory accesses
// R12: Software waits 1 us before memory reads
// R13: Timer register: oscillator bit 7, timers 6:0
// R14: One bit disables change logic, all ports
// R15: Every disable bit clears on reset
// R16: Control registers always readable and writable
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "pmg_defines.svh"

module pmg_periph_gate
  import pmg_pkg::*;
#(
  parameter int DOUT_W = 4,
  parameter int NPORTS = 3,
  parameter logic [11:0] SYSCLK_USERS = 12'hfff,
  parameter int WAKE_CYCLES = `PMG_INSTR_CYC,
  parameter int NVM_WAKE_CYCLES = `PMG_NVM_WAKE_CYC
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic sysclk_en_out,
  output logic [11:0] mod_clk_en_out,
  output logic [11:0] mod_reset_n_out,
  output logic [11:0] analog_en_out,
  input wire logic [12*DOUT_W-1:0] mod_dout_in,
  output logic [12*DOUT_W-1:0] mod_dout_out,
  output logic [NPORTS-1:0] ioc_port_en_out,
  input wire logic [3:0] sfr_sel_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [12*8-1:0] sfr_rdata_in,
  output logic [11:0] sfr_wr_out,
  output logic [7:0] sfr_wdata_out,
  output logic [7:0] sfr_rdata_out,
  input wire logic ee_rd_in,
  input wire logic ee_wr_in,
  input wire logic [7:0] ind_ee_data_in,
  output logic ee_rd_out,
  output logic ee_wr_out,
  output logic [7:0] ind_ee_data_out,
  output logic nvm_ready_out
);

  localparam int NMOD = `PMG_NMOD;

  // ----------------------------------------------------------------
  // Control registers and APB slave
  // ----------------------------------------------------------------
  pmg_byte_t ctrl0;
  pmg_byte_t timers;
  pmg_byte_t next_ctrl0;
  pmg_byte_t next_timers;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic setup;
  logic access;
  logic hit_ctrl0;
  logic hit_timers;

  always_comb begin
    setup = psel_in && !penable_in;
    access = psel_in && penable_in && pready_out;
    hit_ctrl0 = (paddr_in == `PMG_OFF_CTRL0);
    hit_timers = (paddr_in == `PMG_OFF_TIMERS);
    next_ctrl0 = ctrl0;
    next_timers = timers;
    // Registers never gate themselves, so software can always recover
    if (access && pwrite_in && !pslverr_out && pstrb_in[0]) begin // R16
      if (hit_ctrl0) begin
        next_ctrl0 = pwdata_in[7:0] & `PMG_CTRL0_WMASK; // R9
      end
      if (hit_timers) begin
        next_timers = pwdata_in[7:0]; // R13
      end
    end
    // Answer is prepared in setup, presented in the one access cycle
    next_pready = setup;
    next_pslverr = setup && !(hit_ctrl0 || hit_timers);
    next_prdata = 32'h0000_0000;
    if (setup && !pwrite_in) begin
      if (hit_ctrl0) begin
        next_prdata = {24'h00_0000, ctrl0}; // R16
      end else if (hit_timers) begin
        next_prdata = {24'h00_0000, timers};
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl0 <= `PMG_CTRL0_RST; // R15
      timers <= `PMG_TIMERS_RST; // R15
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      ctrl0 <= next_ctrl0;
      timers <= next_timers;
      prdata_out <= next_prdata;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Module slots
  // ----------------------------------------------------------------
  // Slots: 0 change logic, 1 clock ref, 2 memory, 3 voltage ref,
  // 4..10 timers 0..6, 11 numeric oscillator.
  logic [NMOD-1:0] mod_off;
  logic [NMOD-1:0] mod_active;
  logic sysclk_on;

  always_comb begin
    mod_off = {timers, ctrl0[`PMG_BIT_VREF], ctrl0[`PMG_BIT_NVM],
      ctrl0[`PMG_BIT_CLKREF], ctrl0[`PMG_BIT_IOC]}; // R10 R13
    sysclk_on = !ctrl0[`PMG_BIT_SYSCLK]; // R8 R10
  end

  for (genvar g = 0; g < NMOD; g++) begin : g_slot
    pmg_gate_cell #(
      .WAKE_CYCLES(WAKE_CYCLES),
      .USES_SYSCLK(SYSCLK_USERS[g])
    ) u_cell (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .off_in(mod_off[g]),
      .sysclk_on_in(sysclk_on),
      .clk_en_out(mod_clk_en_out[g]),
      .mod_reset_n_out(mod_reset_n_out[g]),
      .active_out(mod_active[g])
    );
  end

  pmg_wake_timer #(
    .CYCLES(NVM_WAKE_CYCLES)
  ) u_nvm_wake (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    // Drop ready in the same cycle as the slot enables fall
    .arm_in(mod_active[`PMG_IDX_NVM] && !mod_off[`PMG_IDX_NVM]),
    .done_out(nvm_ready_out)
  );

  // ----------------------------------------------------------------
  // Output forcing and register access fabric
  // ----------------------------------------------------------------
  logic next_sysclk_en;
  logic [NMOD-1:0] next_analog_en;
  logic [NMOD*DOUT_W-1:0] next_mod_dout;
  logic [NPORTS-1:0] next_ioc_port_en;
  logic [NMOD-1:0] next_sfr_wr;
  pmg_byte_t next_sfr_wdata;
  pmg_byte_t next_sfr_rdata;
  logic next_ee_rd;
  logic next_ee_wr;
  pmg_byte_t next_ind_ee_data;
  logic nvm_on;

  always_comb begin
    nvm_on = mod_active[`PMG_IDX_NVM];
    next_sysclk_en = sysclk_on; // R8
    // Masked by the control bit so analog drops with the module reset
    next_analog_en = mod_active & ~mod_off; // R4
    next_ioc_port_en = {NPORTS{mod_active[`PMG_IDX_IOC]}}; // R14
    next_sfr_wdata = sfr_wdata_in;
    next_sfr_rdata = 8'h00;
    for (int i = 0; i < NMOD; i++) begin
      next_mod_dout[i*DOUT_W +: DOUT_W] = mod_active[i] ?
        mod_dout_in[i*DOUT_W +: DOUT_W] : '0; // R4
      // Covers the memory control registers as well
      next_sfr_wr[i] = sfr_wr_in && (sfr_sel_in == 4'(i)) &&
        mod_active[i] && !mod_off[i]; // R3 R11
      if ((sfr_sel_in == 4'(i)) && mod_active[i]) begin
        next_sfr_rdata = sfr_rdata_in[i*8 +: 8]; // R3
      end
    end
    next_ee_rd = ee_rd_in && nvm_on; // R11
    next_ee_wr = ee_wr_in && nvm_on; // R11
    next_ind_ee_data = nvm_on ? ind_ee_data_in : 8'h00; // R11
  end

  // Outputs are registered so the slot gating adds one flat cycle
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sysclk_en_out <= 1'b1;
      analog_en_out <= '1;
      mod_dout_out <= '0;
      ioc_port_en_out <= '1;
      sfr_wr_out <= '0;
      sfr_wdata_out <= 8'h00;
      sfr_rdata_out <= 8'h00;
      ee_rd_out <= 1'b0;
      ee_wr_out <= 1'b0;
      ind_ee_data_out <= 8'h00;
    end else begin
      sysclk_en_out <= next_sysclk_en;
      analog_en_out <= next_analog_en;
      mod_dout_out <= next_mod_dout;
      ioc_port_en_out <= next_ioc_port_en;
      sfr_wr_out <= next_sfr_wr;
      sfr_wdata_out <= next_sfr_wdata;
      sfr_rdata_out <= next_sfr_rdata;
      ee_rd_out <= next_ee_rd;
      ee_wr_out <= next_ee_wr;
      ind_ee_data_out <= next_ind_ee_data;
    end
  end

endmodule : pmg_periph_gate

// file: include/pmg_defines.svh
// Register map, field positions, reset values and timing counts
`ifndef PMG_DEFINES_SVH
`define PMG_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets on the APB bus
// ----------------------------------------------------------------
`define PMG_OFF_CTRL0 8'h00
`define PMG_OFF_TIMERS 8'h04

// ----------------------------------------------------------------
// Reset values and writable bits
// ----------------------------------------------------------------
`define PMG_CTRL0_RST 8'h00
`define PMG_TIMERS_RST 8'h00
`define PMG_CTRL0_WMASK 8'hc7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMG_BIT_SYSCLK 7
`define PMG_BIT_VREF 6
`define PMG_BIT_NVM 2
`define PMG_BIT_CLKREF 1
`define PMG_BIT_IOC 0
`define PMG_BIT_NCO 7

// ----------------------------------------------------------------
// Gated module slots
// ----------------------------------------------------------------
`define PMG_NMOD 12
`define PMG_IDX_IOC 0
`define PMG_IDX_NVM 2
`define PMG_IDX_VREF 3
`define PMG_IDX_TMR0 4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMG_CLK_PERIOD_NS 40
`define PMG_INSTR_CYC 4
`define PMG_NVM_WAKE_NS 1000
`define PMG_NVM_WAKE_CYC (((`PMG_NVM_WAKE_NS) / (`PMG_CLK_PERIOD_NS)) < 1 ? \
  1 : ((`PMG_NVM_WAKE_NS) / (`PMG_CLK_PERIOD_NS)))

`endif

// file: include/pmg_pkg.sv
// Types shared by the peripheral gating logic
package pmg_pkg;

  typedef enum logic [1:0] {
    pmg_st_off,
    pmg_st_wake,
    pmg_st_on
  } pmg_gate_state_t;

  typedef logic [7:0] pmg_byte_t;

endpackage : pmg_pkg

// file: src/pmg_gate_cell.sv
// One gated peripheral slot: clock enable, held reset and wake delay
`timescale 1ns/100ps
`include "pmg_defines.svh"

module pmg_gate_cell
  import pmg_pkg::*;
#(
  parameter int WAKE_CYCLES = `PMG_INSTR_CYC,
  parameter bit USES_SYSCLK = 1'b1
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic off_in,
  input wire logic sysclk_on_in,
  output logic clk_en_out,
  output logic mod_reset_n_out,
  output logic active_out
);

  localparam int CW = $clog2(WAKE_CYCLES + 1);

  pmg_gate_state_t state;
  pmg_gate_state_t next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_clk_en;
  logic next_mod_reset_n;
  logic next_active;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      pmg_st_off: begin
        if (!off_in) begin
          next_state = pmg_st_wake;
          next_cnt = CW'(WAKE_CYCLES - 1);
        end
      end
      pmg_st_wake: begin
        if (off_in) begin
          next_state = pmg_st_off;
        end else if (cnt == '0) begin
          next_state = pmg_st_on;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      pmg_st_on: begin
        if (off_in) begin
          next_state = pmg_st_off;
        end
      end
      default: begin
        next_state = pmg_st_off;
      end
    endcase
    // Clock runs while waking so the module settles into reset state
    next_clk_en = (next_state != pmg_st_off) &&
      (sysclk_on_in || !USES_SYSCLK); // R1 R8
    next_mod_reset_n = (next_state == pmg_st_on); // R2 R5
    next_active = (next_state == pmg_st_on); // R6
  end

  // Reset leaves every slot running, as software expects after power-up
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= pmg_st_on;
      cnt <= '0;
      clk_en_out <= 1'b1;
      mod_reset_n_out <= 1'b1;
      active_out <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      clk_en_out <= next_clk_en;
      mod_reset_n_out <= next_mod_reset_n;
      active_out <= next_active;
    end
  end

endmodule : pmg_gate_cell

// file: src/pmg_wake_timer.sv
// Counts a fixed settle time after a level rises, then flags ready
`timescale 1ns/100ps
`include "pmg_defines.svh"

module pmg_wake_timer
  import pmg_pkg::*;
#(
  parameter int CYCLES = `PMG_NVM_WAKE_CYC
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic arm_in,
  output logic done_out
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_done;

  always_comb begin
    next_cnt = cnt;
    if (!arm_in) begin
      next_cnt = CW'(CYCLES);
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end
    next_done = arm_in && (next_cnt == '0);
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt <= CW'(CYCLES);
      done_out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done_out <= next_done;
    end
  end

endmodule : pmg_wake_timer

// file: tb/pmg_periph_gate_assertions.sv
// Concurrent checks on the ports of the peripheral gating controller
`timescale 1ns/100ps
module pmg_periph_gate_assertions
  import pmg_pkg::*;
#(parameter int NPORTS = 3) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic sysclk_en_out,
  input wire logic [11:0] mod_clk_en_out,
  input wire logic [11:0] mod_reset_n_out,
  input wire logic [11:0] analog_en_out,
  input wire logic [NPORTS-1:0] ioc_port_en_out,
  input wire logic [11:0] sfr_wr_out,
  input wire logic nvm_ready_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  property p_ready;
    psel_in && !penable_in |=> pready_out;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err;
    pready_out |-> pslverr_out == !(paddr_in inside {8'h00, 8'h04});
  endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  property p_held;
    (analog_en_out & ~mod_reset_n_out) == 12'h000;
  endproperty
  a_held: assert property (p_held) else $error("live in reset");
  // Reset must be released only after a clocked stay in reset
  property p_wake;
    $rose(mod_reset_n_out[2]) && $past(sysclk_en_out, 3)
      |-> $past(mod_clk_en_out[2], 3) && !$past(mod_reset_n_out[2], 3);
  endproperty
  a_wake: assert property (p_wake) else $error("short wake");
  property p_sfr;
    |sfr_wr_out |-> (sfr_wr_out & ~$past(analog_en_out)) == 12'h000;
  endproperty
  a_sfr: assert property (p_sfr) else $error("write to off slot");
  property p_nvm;
    nvm_ready_out |-> analog_en_out[2];
  endproperty
  a_nvm: assert property (p_nvm) else $error("memory ready while off");
  property p_ioc;
    &ioc_port_en_out || !(|ioc_port_en_out);
  endproperty
  a_ioc: assert property (p_ioc) else $error("ports split");
  property p_sys;
    !sysclk_en_out |-> mod_clk_en_out == 12'h000;
  endproperty
  a_sys: assert property (p_sys) else $error("clock leaks");
endmodule : pmg_periph_gate_assertions

bind pmg_periph_gate pmg_periph_gate_assertions #(.NPORTS(NPORTS)) u_chk (
  .mclk_in, .reset_n_in, .psel_in, .penable_in, .paddr_in, .pready_out,
  .pslverr_out, .sysclk_en_out, .mod_clk_en_out, .mod_reset_n_out,
  .analog_en_out, .ioc_port_en_out, .sfr_wr_out, .nvm_ready_out);

// file: tb/pmg_slot_model.sv
// Behavioural stand-in for the twelve gated peripheral slots
`timescale 1ns/100ps
module pmg_slot_model
  import pmg_pkg::*;
#(parameter int DOUT_W = 4) (
  input wire logic mclk_in,
  input wire logic [11:0] clk_en_in,
  input wire logic [11:0] reset_n_in,
  input wire logic [11:0] wr_in,
  input wire logic [7:0] wdata_in,
  output logic [12*8-1:0] rdata_out,
  output logic [12*DOUT_W-1:0] dout_out
);
  pmg_byte_t regs [12];
  always_ff @(posedge mclk_in) begin
    for (int k = 0; k < 12; k++) begin
      if (!reset_n_in[k]) begin
        regs[k] <= 8'h00;
      end else if (clk_en_in[k] && wr_in[k]) begin
        regs[k] <= wdata_in;
      end
    end
  end
  // A slot in reset shows junk, so the controller must mask it
  always_comb begin
    for (int k = 0; k < 12; k++) begin
      rdata_out[k*8 +: 8] = reset_n_in[k] ? regs[k] : 8'ha5;
      dout_out[k*DOUT_W +: DOUT_W] = reset_n_in[k] ? regs[k][DOUT_W-1:0] : '1;
    end
  end
endmodule : pmg_slot_model

// file: tb/pmg_periph_gate_tb.sv
// Self-checking bench for the peripheral gating controller
`timescale 1ns/100ps
`include "pmg_defines.svh"
module pmg_periph_gate_tb;
  import pmg_pkg::*;
  localparam int DW = 4;
  localparam int NW = 2;
  localparam int WK = `PMG_INSTR_CYC;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00, a, b;
  logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd;
  logic pready_out, pslverr_out, sysclk_en_out, nvm_ready_out, err;
  logic [11:0] mod_clk_en_out, mod_reset_n_out, analog_en_out, sfr_wr_out, m;
  logic [12*DW-1:0] mod_dout_in, mod_dout_out;
  logic [2:0] ioc_port_en_out;
  logic [3:0] sfr_sel_in = 4'hf;
  logic sfr_wr_in = 1'b0, ee_rd_in = 1'b1, ee_wr_in = 1'b1;
  logic [7:0] sfr_wdata_in = 8'h00, sfr_wdata_out, sfr_rdata_out;
  logic [95:0] sfr_rdata_in;
  logic ee_rd_out, ee_wr_out;
  logic [7:0] ind_ee_data_out;
  int bad_count = 0;
  int comparisons = 0;

  always #20 mclk_in = ~mclk_in;

  pmg_periph_gate #(.NVM_WAKE_CYCLES(NW)) dut (.mclk_in, .reset_n_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .pstrb_in(4'h1), .prdata_out, .pready_out, .pslverr_out, .sysclk_en_out,
    .mod_clk_en_out, .mod_reset_n_out, .analog_en_out, .mod_dout_in,
    .mod_dout_out, .ioc_port_en_out, .sfr_sel_in, .sfr_wr_in, .sfr_wdata_in,
    .sfr_rdata_in, .sfr_wr_out, .sfr_wdata_out, .sfr_rdata_out, .ee_rd_in,
    .ee_wr_in, .ind_ee_data_in(8'h5a), .ee_rd_out, .ee_wr_out,
    .ind_ee_data_out, .nvm_ready_out);

  pmg_slot_model #(.DOUT_W(DW)) u_slots (.mclk_in,
    .clk_en_in(mod_clk_en_out), .reset_n_in(mod_reset_n_out),
    .wr_in(sfr_wr_out), .wdata_in(sfr_wdata_out),
    .rdata_out(sfr_rdata_in), .dout_out(mod_dout_in));

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // Idle edge first, so two calls never drive psel twice in one step
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= ad;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    // Look while ready stands, then let the sampling edge pass
    do begin
      @(negedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
    end
    rd = prdata_out;
    err = pslverr_out;
    @(posedge mclk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic wait_c(input int n);
    repeat (n) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask : wait_c

  task automatic sfr(input logic [3:0] s, input logic w, input logic [7:0] d);
    @(posedge mclk_in);
    sfr_sel_in <= s;
    sfr_wr_in <= w;
    sfr_wdata_in <= d;
    @(posedge mclk_in);
    sfr_wr_in <= 1'b0;
    wait_c(3);
  endtask : sfr

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    apb(0, 8'h00, 0);
    check(rd, 0);
    apb(0, 8'h04, 0);
    check(rd, 0);
    apb(1, 8'h00, 32'h0000_00ff);
    apb(0, 8'h00, 0);
    check(rd, 32'h0000_00c7);
    apb(1, 8'h00, 0);
    apb(0, 8'h08, 0);
    check({err, rd}, 33'h1_0000_0000);
    for (int i = 0; i < 12; i++) begin
      a = (i < 4) ? 8'h00 : 8'h04;
      b = (i < 4) ? ((i == 3) ? 8'h40 : 8'h01 << i) : 8'h01 << (i - 4);
      m = ~(12'h001 << i);
      apb(1, a, {24'h0, b});
      wait_c(2);
      check(mod_reset_n_out, m);
      check(analog_en_out, m);
      check(mod_clk_en_out, m);
      check(ioc_port_en_out, (i == 0) ? 3'h0 : 3'h7);
      check({ee_rd_out, ee_wr_out}, (i == 2) ? 2'h0 : 2'h3);
      check(ind_ee_data_out, (i == 2) ? 8'h00 : 8'h5a);
      apb(0, a, 0);
      check(rd, b);
      apb(1, a, 0);
      wait_c(WK + 1);
      check(mod_reset_n_out, 12'hfff);
      wait_c(NW + 1);
      check(nvm_ready_out, 1);
    end
    sfr(4'h5, 1, 8'h5a);
    check(sfr_rdata_out, 8'h5a);
    check(mod_dout_out[5*DW +: DW], 4'ha);
    apb(1, 8'h04, 32'h0000_0002);
    wait_c(2);
    check(sfr_rdata_out, 0);
    check(mod_dout_out[5*DW +: DW], 0);
    sfr(4'h5, 1, 8'h33);
    apb(1, 8'h04, 0);
    wait_c(WK + 1);
    sfr(4'h5, 0, 8'h00);
    check(sfr_rdata_out, 0);
    sfr(4'h5, 1, 8'h77);
    check(sfr_rdata_out, 8'h77);
    apb(1, 8'h00, 32'h0000_0080);
    wait_c(2);
    check({sysclk_en_out, mod_clk_en_out}, 0);
    apb(1, 8'h00, 0);
    wait_c(2);
    check(sysclk_en_out, 1);
    give_verdict();
  end

  // About 290 cycles are needed; this leaves ample margin
  initial begin
    repeat (5000) @(posedge mclk_in);
    bad_count++;
    give_verdict();
  end
endmodule : pmg_periph_gate_tb
